// >>> hw/gpw_defines.svh
// Register offsets, field widths, reset values and timing counts for the GPIO port block
`ifndef GPW_DEFINES_SVH
`define GPW_DEFINES_SVH

// Byte addresses on the register bus (word aligned)
`define GPW_OFF_PA_DATA 8'h00
`define GPW_OFF_PA_DIR 8'h04
`define GPW_OFF_PA_PULL 8'h08
`define GPW_OFF_PA_WAKE 8'h0C
`define GPW_OFF_PB_DATA 8'h10
`define GPW_OFF_PB_DIR 8'h14
`define GPW_OFF_PB_PULL 8'h18
`define GPW_OFF_PC_DATA 8'h20
`define GPW_OFF_PC_DIR 8'h24
`define GPW_OFF_PC_PULL 8'h28
`define GPW_OFF_PD_DATA 8'h30
`define GPW_OFF_PD_DIR 8'h34
`define GPW_OFF_PD_PULL 8'h38
`define GPW_OFF_CTRL 8'h40
`define GPW_OFF_STATUS 8'h44

// Implemented bit masks per register
`define GPW_MASK_PA 8'hFF
`define GPW_MASK_PA_PULL 8'h7F
`define GPW_MASK_PB 8'h3F
`define GPW_MASK_PC 8'hFF
`define GPW_MASK_PD 8'h0F
`define GPW_MASK_CTRL 8'h3F

// Reset values
`define GPW_RST_DATA 8'hFF
`define GPW_RST_PA_DIR 8'hFF
`define GPW_RST_PB_DIR 8'h3F
`define GPW_RST_PC_DIR 8'hFF
`define GPW_RST_PD_DIR 8'h0F
`define GPW_RST_ZERO 8'h00

// Control register fields
`define GPW_CTRL_SLEEP 0
`define GPW_CTRL_INT_EN 1
`define GPW_CTRL_TMR_EXT 2
`define GPW_CTRL_PFD_EN 3
`define GPW_CTRL_LCD_EN 4
`define GPW_CTRL_LCD_PHASE 5

// LCD common waveform: system clock cycles per frame step (2 ms at 50 MHz)
`define GPW_LCD_STEP_US 2000
`define GPW_CLK_MHZ 50
`define GPW_LCD_STEP_CYC (`GPW_LCD_STEP_US * `GPW_CLK_MHZ)

`endif

// >>> hw/gpw_pkg.sv
// Types shared by the GPIO port block
package gpw_pkg;

	// Per-port pad control bundle
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pull;
	} gpw_pad_s;

	// Sleep controller state
	typedef enum logic [0:0] {
		GPW_AWAKE,
		GPW_ASLEEP
	} gpw_sleep_e;

	// LCD common level per pin
	typedef enum logic [1:0] {
		GPW_LCD_LOW,
		GPW_LCD_HALF,
		GPW_LCD_HIGH
	} gpw_lcd_e;

endpackage : gpw_pkg

// >>> hw/gpw_gpio_ports.sv
// Four GPIO ports with direction, pull-high, Port A wake-up and shared pin functions
//
// Contract
// - Port A wake-enable bit 1 enables that pin's wake-up, 0 disables it.
// - Direction bit 0 makes the pin a CMOS output, 1 an input; here the top Port A pin is an open-drain output instead.
// - Pull-high bit 1 connects the internal pull-high, 0 removes it; here bit 1 connects it only while the pin's direction is input.
// - Unimplemented register bits always read as zero.
// - Input pin: data read returns present pin level.
// - Output pin: data read returns the output latch, not the pin.
// - Interrupt pin keeps I/O; needs interrupt enable and input direction.
// - Timer input fed only in event/capture mode with input direction.
// - Divider output reaches pins only when direction selects output.
// - Common control turns four Port B pins into half-bias LCD commons.
// - Reset sets data and direction registers high; all pins are inputs.
// - Output switched on without latch write drives high; here the open-drain top Port A pin stays undriven instead.
// - Bit set/clear is read-modify-write of the whole port.
// - In Sleep, falling edge on any wake-enabled Port A pin wakes device.
// - Top Port A pin has no pull-high bit.
// - Halt enters Sleep; clock stops until a wake-up event.
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "gpw_defines.svh"

module gpw_gpio_ports #(
	parameter int LCD_STEP_CYC = `GPW_LCD_STEP_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic avs_response_err,
	input wire logic [7:0] pa_in,
	input wire logic [7:0] pb_in,
	input wire logic [7:0] pc_in,
	input wire logic [7:0] pd_in,
	output logic [7:0] pa_out,
	output logic [7:0] pa_oe,
	output logic [7:0] pa_pull,
	output logic [7:0] pb_out,
	output logic [7:0] pb_oe,
	output logic [7:0] pb_pull,
	output logic [7:0] pc_out,
	output logic [7:0] pc_oe,
	output logic [7:0] pc_pull,
	output logic [7:0] pd_out,
	output logic [7:0] pd_oe,
	output logic [7:0] pd_pull,
	output logic [3:0] lcd_half_bias,
	input wire logic pfd_wave,
	input wire logic [1:0] timer_mode,
	output logic timer_ext_in,
	output logic ext_irq_in,
	output logic sleep_clk_gate,
	output logic wake_pulse
);

	// Pin synchronisers: two flops before any logic looks at a pin
	logic [31:0] pin_meta;
	logic [31:0] pin_sync;
	logic [7:0] pa_s, pb_s, pc_s, pd_s;

	// Registers
	logic [7:0] pa_data, pb_data, pc_data, pd_data;
	logic [7:0] port_a_direction, port_b_direction, port_c_direction, port_d_direction;
	logic [7:0] port_a_pull_high, port_b_pull_high, port_c_pull_high, port_d_pull_high;
	logic [7:0] port_a_wake_enable;
	logic [7:0] misc_ctrl;
	logic [7:0] pa_prev;
	logic ack;
	gpw_pkg::gpw_sleep_e sleep_state;
	gpw_pkg::gpw_lcd_e lcd_level [4];
	logic [31:0] lcd_cnt;
	logic [1:0] lcd_phase;

	// Read value of a data location: latch for outputs, pin for inputs
	function automatic logic [7:0] port_read(
		input logic [7:0] dir,
		input logic [7:0] latch,
		input logic [7:0] pin,
		input logic [7:0] mask
	);
		port_read = ((dir & pin) | (~dir & latch)) & mask;
	endfunction : port_read

	// Write merge honouring the low byte lane and implemented bits
	function automatic logic [7:0] merge(
		input logic [7:0] old,
		input logic [31:0] wd,
		input logic be0,
		input logic [7:0] mask
	);
		merge = be0 ? (wd[7:0] & mask) : old;
	endfunction : merge

	// Two-flop synchroniser for all pins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_meta <= 32'h0000_0000;
			pin_sync <= 32'h0000_0000;
		end else begin
			pin_meta <= {pd_in, pc_in, pb_in, pa_in};
			pin_sync <= pin_meta;
		end
	end

	// Synchronised pin levels per port
	assign pa_s = pin_sync[7:0];
	assign pb_s = pin_sync[15:8];
	assign pc_s = pin_sync[23:16];
	assign pd_s = pin_sync[31:24];

	// Writes commit at the completion edge, where waitrequest is already low
	// Committing on the first edge would land a write the master still sees as waiting
	logic wr_hit;
	assign wr_hit = avs_write & ack;

	// Data latches; a bit set/clear done by software as read-modify-write lands here whole
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pa_data <= `GPW_RST_DATA;
			pb_data <= `GPW_RST_DATA & `GPW_MASK_PB;
			pc_data <= `GPW_RST_DATA;
			pd_data <= `GPW_RST_DATA & `GPW_MASK_PD;
		end else if (wr_hit) begin
			case (avs_address)
				`GPW_OFF_PA_DATA: pa_data <= merge(pa_data, avs_writedata, avs_byteenable[0],
					`GPW_MASK_PA);
				`GPW_OFF_PB_DATA: pb_data <= merge(pb_data, avs_writedata, avs_byteenable[0],
					`GPW_MASK_PB);
				`GPW_OFF_PC_DATA: pc_data <= merge(pc_data, avs_writedata, avs_byteenable[0],
					`GPW_MASK_PC);
				`GPW_OFF_PD_DATA: pd_data <= merge(pd_data, avs_writedata, avs_byteenable[0],
					`GPW_MASK_PD);
				default: ;
			endcase
		end
	end

	// Direction registers; reset makes every pin an input
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			port_a_direction <= `GPW_RST_PA_DIR;
			port_b_direction <= `GPW_RST_PB_DIR;
			port_c_direction <= `GPW_RST_PC_DIR;
			port_d_direction <= `GPW_RST_PD_DIR;
		end else if (wr_hit) begin
			case (avs_address)
				`GPW_OFF_PA_DIR: port_a_direction <= merge(port_a_direction, avs_writedata,
					avs_byteenable[0], `GPW_MASK_PA);
				`GPW_OFF_PB_DIR: port_b_direction <= merge(port_b_direction, avs_writedata,
					avs_byteenable[0], `GPW_MASK_PB);
				`GPW_OFF_PC_DIR: port_c_direction <= merge(port_c_direction, avs_writedata,
					avs_byteenable[0], `GPW_MASK_PC);
				`GPW_OFF_PD_DIR: port_d_direction <= merge(port_d_direction, avs_writedata,
					avs_byteenable[0], `GPW_MASK_PD);
				default: ;
			endcase
		end
	end

	// Pull-high and wake-enable registers
	// The top Port A pull bit is masked so it can never be set
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			port_a_pull_high <= `GPW_RST_ZERO;
			port_b_pull_high <= `GPW_RST_ZERO;
			port_c_pull_high <= `GPW_RST_ZERO;
			port_d_pull_high <= `GPW_RST_ZERO;
			port_a_wake_enable <= `GPW_RST_ZERO;
		end else if (wr_hit) begin
			case (avs_address)
				`GPW_OFF_PA_PULL: port_a_pull_high <= merge(port_a_pull_high, avs_writedata,
					avs_byteenable[0], `GPW_MASK_PA_PULL);
				`GPW_OFF_PB_PULL: port_b_pull_high <= merge(port_b_pull_high, avs_writedata,
					avs_byteenable[0], `GPW_MASK_PB);
				`GPW_OFF_PC_PULL: port_c_pull_high <= merge(port_c_pull_high, avs_writedata,
					avs_byteenable[0], `GPW_MASK_PC);
				`GPW_OFF_PD_PULL: port_d_pull_high <= merge(port_d_pull_high, avs_writedata,
					avs_byteenable[0], `GPW_MASK_PD);
				`GPW_OFF_PA_WAKE: port_a_wake_enable <= merge(port_a_wake_enable,
					avs_writedata, avs_byteenable[0], `GPW_MASK_PA);
				default: ;
			endcase
		end
	end

	// Wake-up source: falling edge on an enabled Port A pin
	logic wake_event;
	assign wake_event = |(pa_prev & ~pa_s & port_a_wake_enable);

	// Previous synchronised Port A levels for edge detection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pa_prev <= `GPW_RST_ZERO;
		end else begin
			pa_prev <= pa_s;
		end
	end

	// Misc control: sleep request bit is cleared by hardware on wake-up
	// A software write in the wake cycle takes priority over the hardware clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			misc_ctrl <= `GPW_RST_ZERO;
		end else if (wr_hit && avs_address == `GPW_OFF_CTRL && avs_byteenable[0]) begin
			misc_ctrl <= avs_writedata[7:0] & `GPW_MASK_CTRL;
		end else if (sleep_state == gpw_pkg::GPW_ASLEEP && wake_event) begin
			misc_ctrl[`GPW_CTRL_SLEEP] <= 1'b0;
		end
	end

	// Sleep controller: halt stops the core clock until a wake event
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sleep_state <= gpw_pkg::GPW_AWAKE;
		end else begin
			case (sleep_state)
				gpw_pkg::GPW_AWAKE:
					if (misc_ctrl[`GPW_CTRL_SLEEP]) sleep_state <= gpw_pkg::GPW_ASLEEP;
				gpw_pkg::GPW_ASLEEP:
					if (wake_event) sleep_state <= gpw_pkg::GPW_AWAKE;
				default: sleep_state <= gpw_pkg::GPW_AWAKE;
			endcase
		end
	end

	// One-cycle pulse on the cycle the device leaves Sleep
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wake_pulse <= 1'b0;
		end else begin
			wake_pulse <= (sleep_state == gpw_pkg::GPW_ASLEEP) && wake_event;
		end
	end

	// Clock gate request to the core while asleep
	assign sleep_clk_gate = (sleep_state == gpw_pkg::GPW_ASLEEP);

	// LCD common timing: step counter and four-step frame phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lcd_cnt <= 32'h0000_0000;
			lcd_phase <= 2'h0;
		end else if (!misc_ctrl[`GPW_CTRL_LCD_EN]) begin
			lcd_cnt <= 32'h0000_0000;
			lcd_phase <= 2'h0;
		end else if (lcd_cnt == 32'(LCD_STEP_CYC - 1)) begin
			lcd_cnt <= 32'h0000_0000;
			lcd_phase <= lcd_phase + 2'h1;
		end else begin
			lcd_cnt <= lcd_cnt + 32'h0000_0001;
		end
	end

	// Half-bias levels: selected common swings full, others sit at mid level
	// Only the common whose step is current is driven; the other three float at half bias
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lcd
			always_comb begin
				if (lcd_phase != 2'(gi)) begin
					lcd_level[gi] = gpw_pkg::GPW_LCD_HALF;
				end else if (misc_ctrl[`GPW_CTRL_LCD_PHASE]) begin
					lcd_level[gi] = gpw_pkg::GPW_LCD_HIGH;
				end else begin
					lcd_level[gi] = gpw_pkg::GPW_LCD_LOW;
				end
			end
			assign lcd_half_bias[gi] = misc_ctrl[`GPW_CTRL_LCD_EN]
				&& lcd_level[gi] == gpw_pkg::GPW_LCD_HALF;
		end
	endgenerate

	// Port A pad drive: divider on pins 0/1, top pin open-drain
	always_comb begin
		pa_out = pa_data;
		if (misc_ctrl[`GPW_CTRL_PFD_EN]) begin
			pa_out[0] = pfd_wave;
			pa_out[1] = ~pfd_wave;
		end
		pa_oe = ~port_a_direction;
		pa_oe[7] = ~port_a_direction[7] & ~pa_data[7];
		pa_out[7] = 1'b0;
		pa_pull = port_a_pull_high & port_a_direction & `GPW_MASK_PA_PULL;
	end

	// Port B pad drive: low four pins may carry LCD commons
	always_comb begin
		pb_out = pb_data & `GPW_MASK_PB;
		pb_oe = ~port_b_direction & `GPW_MASK_PB;
		pb_pull = port_b_pull_high & port_b_direction & `GPW_MASK_PB;
		if (misc_ctrl[`GPW_CTRL_LCD_EN]) begin
			for (int i = 0; i < 4; i++) begin
				pb_out[i] = (lcd_level[i] == gpw_pkg::GPW_LCD_HIGH);
				pb_oe[i] = ~lcd_half_bias[i];
				pb_pull[i] = 1'b0;
			end
		end
	end

	// Ports C and D pad drive, gathered per port as one pad bundle
	gpw_pkg::gpw_pad_s pad_c;
	gpw_pkg::gpw_pad_s pad_d;
	always_comb begin
		pad_c.out = pc_data;
		pad_c.oe = ~port_c_direction;
		pad_c.pull = port_c_pull_high & port_c_direction;
		pad_d.out = pd_data & `GPW_MASK_PD;
		pad_d.oe = ~port_d_direction & `GPW_MASK_PD;
		pad_d.pull = port_d_pull_high & port_d_direction & `GPW_MASK_PD;
	end

	// Bundles out to the pins
	assign pc_out = pad_c.out;
	assign pc_oe = pad_c.oe;
	assign pc_pull = pad_c.pull;
	assign pd_out = pad_d.out;
	assign pd_oe = pad_d.oe;
	assign pd_pull = pad_d.pull;

	// Shared inputs: interrupt on PA3, timer input on PA4, both need input direction
	assign ext_irq_in = misc_ctrl[`GPW_CTRL_INT_EN] & port_a_direction[3] & pa_s[3];
	assign timer_ext_in = misc_ctrl[`GPW_CTRL_TMR_EXT] & (timer_mode == 2'h1
		|| timer_mode == 2'h3) & port_a_direction[4] & pa_s[4];

	// Bus slave: one wait cycle, then answer with registered read data
	// Read data loads on the first edge and stands through the completion edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack <= 1'b0;
			avs_readdata <= 32'h0000_0000;
			avs_response_err <= 1'b0;
		end else begin
			ack <= (avs_read | avs_write) & ~ack;
			if (avs_read && !ack) begin
				avs_response_err <= 1'b0;
				case (avs_address)
					`GPW_OFF_PA_DATA: avs_readdata <= {24'h00_0000,
						port_read(port_a_direction, pa_data, pa_s, `GPW_MASK_PA)};
					`GPW_OFF_PB_DATA: avs_readdata <= {24'h00_0000,
						port_read(port_b_direction, pb_data, pb_s, `GPW_MASK_PB)};
					`GPW_OFF_PC_DATA: avs_readdata <= {24'h00_0000,
						port_read(port_c_direction, pc_data, pc_s, `GPW_MASK_PC)};
					`GPW_OFF_PD_DATA: avs_readdata <= {24'h00_0000,
						port_read(port_d_direction, pd_data, pd_s, `GPW_MASK_PD)};
					`GPW_OFF_PA_DIR: avs_readdata <= {24'h00_0000, port_a_direction};
					`GPW_OFF_PB_DIR: avs_readdata <= {24'h00_0000, port_b_direction};
					`GPW_OFF_PC_DIR: avs_readdata <= {24'h00_0000, port_c_direction};
					`GPW_OFF_PD_DIR: avs_readdata <= {24'h00_0000, port_d_direction};
					`GPW_OFF_PA_PULL: avs_readdata <= {24'h00_0000, port_a_pull_high};
					`GPW_OFF_PB_PULL: avs_readdata <= {24'h00_0000, port_b_pull_high};
					`GPW_OFF_PC_PULL: avs_readdata <= {24'h00_0000, port_c_pull_high};
					`GPW_OFF_PD_PULL: avs_readdata <= {24'h00_0000, port_d_pull_high};
					`GPW_OFF_PA_WAKE: avs_readdata <= {24'h00_0000, port_a_wake_enable};
					`GPW_OFF_CTRL: avs_readdata <= {24'h00_0000, misc_ctrl};
					`GPW_OFF_STATUS: avs_readdata <= {22'h00_0000, lcd_phase,
						6'h00, 1'b0, sleep_state == gpw_pkg::GPW_ASLEEP};
					default: begin
						avs_readdata <= 32'h0000_0000;
						avs_response_err <= 1'b1;
					end
				endcase
			end
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ack;

endmodule : gpw_gpio_ports

// >>> dv/gpw_gpio_ports_props.sv
// Checker of bus and pad relations for the GPIO port block
`timescale 1ns/1ps
module gpw_gpio_ports_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [7:0] pa_out,
	input wire logic [7:0] pa_oe,
	input wire logic [7:0] pa_pull,
	input wire logic [7:0] pb_oe,
	input wire logic [7:0] pb_pull,
	input wire logic [7:0] pc_oe,
	input wire logic [7:0] pd_oe,
	input wire logic [3:0] lcd_half_bias,
	input wire logic [1:0] timer_mode,
	input wire logic timer_ext_in,
	input wire logic ext_irq_in,
	input wire logic sleep_clk_gate,
	input wire logic wake_pulse
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// A fresh request, then its completion cycle
	sequence s_new_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_done;
		!avs_waitrequest && avs_readdata[31:8] == 24'h00_0000;
	endsequence
	// Bus answer one cycle later with empty upper lanes
	a_ack_next_cycle: assert property (s_new_req |=> s_done)
		else $error("bus answer late or upper read bits set");
	// Pad rules
	a_top_pin_low: assert property (pa_out[7] == 1'b0)
		else $error("top port A pin driven high");
	a_pull_inputs_only: assert property ((pa_pull & pa_oe) == 8'h00 && (pb_pull & pb_oe) == 8'h00)
		else $error("pull-high on while pin drives");
	a_top_pull_absent: assert property (!pa_pull[7])
		else $error("pull-high on top port A pin");
	a_reset_inputs: assert property ($fell(rst) |-> (pa_oe | pb_oe | pc_oe | pd_oe) == 8'h00)
		else $error("pin driving right after reset");
	a_lcd_no_drive: assert property ((lcd_half_bias & pb_oe[3:0]) == 4'h0)
		else $error("pad driven while common at half level");
	a_timer_mode_gate: assert property (timer_ext_in |-> timer_mode[0] && !pa_oe[4])
		else $error("timer input passed in wrong mode or direction");
	a_irq_input_only: assert property (ext_irq_in |-> !pa_oe[3])
		else $error("interrupt input passed while pin is output");
	// Wake pulse: one cycle long, only on leaving Sleep
	sequence s_left_sleep;
		$past(sleep_clk_gate) && !sleep_clk_gate;
	endsequence
	a_wake_from_sleep: assert property (wake_pulse |-> s_left_sleep)
		else $error("wake pulse without leaving sleep");
	a_wake_one_cycle: assert property (wake_pulse |=> !wake_pulse)
		else $error("wake pulse longer than one cycle");
endmodule : gpw_gpio_ports_props

bind gpw_gpio_ports gpw_gpio_ports_props u_props (
	.clk(clk),
	.rst(rst),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.pa_out(pa_out),
	.pa_oe(pa_oe),
	.pa_pull(pa_pull),
	.pb_oe(pb_oe),
	.pb_pull(pb_pull),
	.pc_oe(pc_oe),
	.pd_oe(pd_oe),
	.lcd_half_bias(lcd_half_bias),
	.timer_mode(timer_mode),
	.timer_ext_in(timer_ext_in),
	.ext_irq_in(ext_irq_in),
	.sleep_clk_gate(sleep_clk_gate),
	.wake_pulse(wake_pulse)
);

// >>> dv/gpw_pin_model.sv
// Board-side model of one eight-pin port: switches, loads and floating lines
`timescale 1ns/1ps
module gpw_pin_model (
	input wire logic clk,
	input wire logic [7:0] out,
	input wire logic [7:0] oe,
	input wire logic [7:0] pull,
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_en,
	output logic [7:0] pin
);
	logic [7:0] drift = 8'h55;
	// Undriven lines without pull-high wander every cycle
	always_ff @(posedge clk) begin
		drift <= ~drift;
	end
	// Pad drive wins, then a switch, then the pull-high, then drift
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (oe[i]) pin[i] = out[i];
			else if (ext_en[i]) pin[i] = ext_val[i];
			else if (pull[i]) pin[i] = 1'b1;
			else pin[i] = drift[i];
		end
	end
endmodule : gpw_pin_model

// >>> dv/test_gpio_ports_with_wakeup.sv
// Self-checking bench for the GPIO port block
`timescale 1ns/1ps
module test_gpio_ports_with_wakeup;
	logic clk, rst, avs_read, avs_write, avs_waitrequest, avs_response_err, e;
	logic [7:0] avs_address, pa_in, pb_in, pc_in, pd_in, pa_out, pa_oe, pa_pull, pb_out, pb_oe;
	logic [7:0] pb_pull, pc_out, pc_oe, pc_pull, pd_out, pd_oe, pd_pull, pa_ext, pa_en;
	logic [7:0] pb_ext, pb_en;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0] avs_byteenable, lcd_half_bias;
	logic [1:0] timer_mode;
	logic pfd_wave, timer_ext_in, ext_irq_in, sleep_clk_gate, wake_pulse;
	int errors, check_count, cyc, n;
	localparam logic [7:0] RA [9] = '{8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h24, 8'h28, 8'h34, 8'h38};
	localparam logic [7:0] RV [9] = '{8'hFF, 8'h00, 8'h00, 8'h3F, 8'h00, 8'hFF, 8'h00, 8'h0F, 8'h00};
	localparam logic [7:0] RM [9] = '{8'hFF, 8'h7F, 8'hFF, 8'h3F, 8'h3F, 8'hFF, 8'hFF, 8'h0F, 8'h0F};
	// Board models and the block
	gpw_pin_model u_pa (.clk(clk), .out(pa_out), .oe(pa_oe), .pull(pa_pull), .ext_val(pa_ext),
		.ext_en(pa_en), .pin(pa_in));
	gpw_pin_model u_pb (.clk(clk), .out(pb_out), .oe(pb_oe), .pull(pb_pull), .ext_val(pb_ext),
		.ext_en(pb_en), .pin(pb_in));
	gpw_pin_model u_pc (.clk(clk), .out(pc_out), .oe(pc_oe), .pull(pc_pull), .ext_val(8'h00),
		.ext_en(8'h00), .pin(pc_in));
	gpw_pin_model u_pd (.clk(clk), .out(pd_out), .oe(pd_oe), .pull(pd_pull), .ext_val(8'h00),
		.ext_en(8'h00), .pin(pd_in));
	gpw_gpio_ports #(.LCD_STEP_CYC(4)) u_dut (.*);
	// Clock and divider waveform
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) pfd_wave <= ~pfd_wave;
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			complete_run();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	// One bus transfer, entered just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h00_0000, d};
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		e = avs_response_err;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check(q, {24'h00_0000, exp});
	endtask : rd_chk
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run
	initial begin
		rst = 1'b1;
		avs_byteenable = 4'hF;
		{avs_read, avs_write, avs_address, avs_writedata, pa_ext, pa_en, timer_mode, pfd_wave} = '0;
		{pb_ext, pb_en} = 16'h0000;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 9; i++) rd_chk(RA[i], RV[i]);
		for (int i = 0; i < 9; i++) begin
			bus(1'b1, RA[i], 8'hFF);
			rd_chk(RA[i], RM[i]);
		end
		check({pa_pull, pb_pull}, 16'h7F3F);
		bus(1'b0, 8'h4C, 8'h00);
		check({31'h0000_0000, e}, 32'h0000_0001);
		check(q, 32'h0000_0000);
		pb_en <= 8'hFF;
		pb_ext <= 8'hA5;
		repeat (3) @(posedge clk);
		rd_chk(8'h10, 8'h25);
		bus(1'b1, 8'h24, 8'h0F);
		check({pc_out, pc_oe, pc_pull}, 24'hFF_F00F);
		bus(1'b1, 8'h34, 8'h00);
		check({pd_out, pd_oe, pd_pull}, 24'h0F_0F00);
		$display("test registers done");
		bus(1'b1, 8'h04, 8'h00);
		check({pa_out, pa_oe, pa_pull}, 24'h7F_7F00);
		pa_en <= 8'hFF;
		repeat (3) @(posedge clk);
		rd_chk(8'h00, 8'hFF);
		bus(1'b1, 8'h04, 8'hFF);
		pa_ext <= 8'h5A;
		repeat (3) @(posedge clk);
		rd_chk(8'h00, 8'h5A);
		bus(1'b1, 8'h00, q[7:0] | 8'h01);
		bus(1'b1, 8'h04, 8'h00);
		check({pa_out, pa_oe}, 16'h5BFF);
		bus(1'b1, 8'h04, 8'hFF);
		$display("test pin data done");
		pa_ext <= 8'hFF;
		bus(1'b1, 8'h0C, 8'h04);
		bus(1'b1, 8'h40, 8'h01);
		@(posedge clk);
		check(sleep_clk_gate, 1'b1);
		pa_ext <= 8'hFE;
		repeat (6) @(posedge clk);
		check({wake_pulse, sleep_clk_gate}, 2'b01);
		pa_ext <= 8'hFA;
		for (n = 0; n < 10 && wake_pulse !== 1'b1; n++) @(negedge clk);
		check(wake_pulse, 1'b1);
		@(negedge clk);
		check(sleep_clk_gate, 1'b0);
		@(posedge clk);
		rd_chk(8'h40, 8'h00);
		$display("test wake done");
		avs_byteenable <= 4'hE;
		bus(1'b1, 8'h0C, 8'h00);
		avs_byteenable <= 4'hF;
		rd_chk(8'h0C, 8'h04);
		timer_mode <= 2'b01;
		bus(1'b1, 8'h40, 8'h0E);
		repeat (3) @(posedge clk);
		check({timer_ext_in, ext_irq_in, pa_oe[1:0]}, 4'hC);
		timer_mode <= 2'b11;
		@(posedge clk);
		check(timer_ext_in, 1'b1);
		timer_mode <= 2'b10;
		bus(1'b1, 8'h04, 8'hFC);
		@(negedge clk);
		check({timer_ext_in, pa_oe[1:0], pa_out[1:0]}, {1'b0, 2'b11, ~pfd_wave, pfd_wave});
		@(posedge clk);
		bus(1'b1, 8'h40, 8'h30);
		for (n = 0; n < 40 && lcd_half_bias !== 4'b0111; n++) @(negedge clk);
		for (n = 0; n < 40 && lcd_half_bias !== 4'b1110; n++) @(negedge clk);
		check({lcd_half_bias, pb_oe[3:0], pb_out[3:0], pb_pull[3:0]}, 16'hE110);
		for (n = 0; n < 40 && lcd_half_bias === 4'b1110; n++) @(negedge clk);
		check(n, 32'h0000_0004);
		check(lcd_half_bias, 4'hD);
		$display("test shared pins done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check({pa_oe, pb_oe, pc_oe, pd_oe}, 32'h0000_0000);
		rd_chk(8'h24, 8'hFF);
		rd_chk(8'h40, 8'h00);
		$display("test reset done");
		complete_run();
	end
endmodule : test_gpio_ports_with_wakeup
